/* seos_enc_counter.sv */
// module: encoder quadrature decoder and modulo-4096 position counter
`timescale 1ns/1ps
`default_nettype none
module seos_enc_counter
    import seos_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire seos_enc_s enc_in,
    input wire logic arm_in,
    output seos_cnt_s cnt_out
);
    typedef struct packed {
        logic prev_a;
        logic prev_b;
        logic prev_mark;
        seos_cnt_s cnt;
    } seos_ec_state_s;

    seos_ec_state_s state;
    seos_ec_state_s next_state;
    logic mark_rise;
    logic [1:0] qd;

    always_comb begin
        next_state = state;
        next_state.prev_a = enc_in.phase_a;
        next_state.prev_b = enc_in.phase_b;
        next_state.prev_mark = enc_in.mark;
        next_state.cnt.fwd_step = 1'b0;
        next_state.cnt.rev_step = 1'b0;
        next_state.cnt.mark_seen = 1'b0;
        mark_rise = enc_in.mark & ~state.prev_mark;
        qd = {state.prev_a ^ enc_in.phase_b, state.prev_b ^ enc_in.phase_a};
        if (qd == 2'h1) begin
            next_state.cnt.fwd_step = 1'b1;
        end else if (qd == 2'h2) begin
            next_state.cnt.rev_step = 1'b1;
        end
        if (!arm_in) begin
            next_state.cnt.counting = 1'b0;
        end else if (mark_rise && !state.cnt.counting) begin
            // position counted from the mark pulse
            next_state.cnt.counting = 1'b1; // [R3]
            next_state.cnt.count = SEOS_REF_STOP_POS; // [R14]
            next_state.cnt.mark_seen = 1'b1;
        end else if (next_state.cnt.fwd_step) begin
            next_state.cnt.count = state.cnt.count + 12'h001; // [R14]
        end else if (next_state.cnt.rev_step) begin
            next_state.cnt.count = state.cnt.count - 12'h001; // [R14]
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign cnt_out = state.cnt;
endmodule
`default_nettype wire

/* seos_enc_model.sv */
// partner: spindle motor with encoder and speed feedback
`timescale 1ns/1ps
`default_nettype none
module seos_enc_model (
    input wire logic clk_in,
    input wire logic slow_in,
    input wire logic [15:0] speed_in,
    input wire logic rev_in,
    input wire logic loop_in,
    input wire logic [11:0] target_in,
    output logic [15:0] meas_out,
    output logic enc_a_out,
    output logic enc_b_out,
    output logic mark_out,
    output logic [11:0] angle_out
);
    logic [1:0] phase = 2'h0;
    logic [4:0] lag = 5'h00;
    logic div = 1'b0;
    logic [15:0] meas = 16'h0000;
    logic [11:0] angle = 12'h000;
    logic step;
    logic back;
    // servo to target in loop, else run at speed; one step is 360/4096 deg
    assign back = loop_in ? (12'(target_in - angle) > 12'h800) : rev_in;
    assign step = loop_in ? (angle != target_in) : (speed_in != 16'h0000 && (speed_in >= 16'h0100 || div));
    always @(posedge clk_in) begin
        div <= !div;
        if (step) begin
            angle <= back ? angle - 12'h001 : angle + 12'h001;
            phase <= back ? phase - 2'h1 : phase + 2'h1;
        end
        // speed feedback lags the target, longer when slow
        if (meas != speed_in) begin
            lag <= lag + 5'h01;
            if (lag >= (slow_in ? 5'h10 : 5'h01)) begin
                meas <= speed_in;
                lag <= 5'h00;
            end
        end
    end
    assign meas_out = meas;
    assign angle_out = angle;
    // channel a leads channel b in forward rotation
    assign enc_a_out = phase[1] ^ phase[0];
    assign enc_b_out = phase[1];
    assign mark_out = (angle == 12'h000);
endmodule
`default_nettype wire

/* seos_orient_seq.sv */
// module: spindle encoder orientation sequencer top
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] on orient command latch stop shift and target orientation speed
// [R2] raise up-to-speed when measured speed reaches orientation speed
// [R3] after up-to-speed start counting at next mark, keep orientation speed
// [R4] switch to creep speed when remaining distance is 146..225 degrees
// [R5] enable position loop at 15..25 degrees remaining, then stop at target
// [R6] close done contact only within target plus/minus in-position range
// [R7] on command release return to external speed reference
// [R8] reorient from oriented state turns at least one full revolution first
// [R9] machine-ready toggling while oriented leaves orientation state unchanged
// [R10] stop position is 12-bit parallel input, all open means zero degrees
// [R11] input is unsigned binary, angle is value times 360 over 4096
// [R12] controller sees 0.088 degree steps, whole degrees carry small error
// [R13] orientation direction: previous, always forward or always reverse
// [R14] count encoder modulo 4096 from mark, derive remaining distance
// [R15] target is stop position plus shift modulo one revolution
module seos_orient_seq
    import seos_pkg::*;
#(
    parameter int SPD_W = SEOS_SPD_W
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic orient_cmd_in,
    input wire logic machine_ready_in_a,
    input wire logic machine_ready_in_b,
    input wire logic [11:0] stop_pos_bits_in,
    input wire logic [11:0] stop_position_shift_in,
    input wire logic [11:0] in_position_range_in,
    input wire logic [1:0] orient_select_param_in,
    input wire logic [SPD_W-1:0] speed_ref_in,
    input wire logic [SPD_W-1:0] orient_speed_in,
    input wire logic [SPD_W-1:0] creep_speed_in,
    input wire logic [SPD_W-1:0] meas_speed_in,
    input wire logic motor_reverse_in,
    input wire logic enc_a_in,
    input wire logic enc_b_in,
    input wire logic enc_mark_in,
    output logic [SPD_W-1:0] speed_target_out,
    output logic dir_reverse_out,
    output logic up_to_speed_out,
    output logic pos_loop_en_out,
    output logic [11:0] pos_target_out,
    output logic orient_done_contact,
    output logic oriented_out
);
    // ----------------------------------------
    // reset and pin synchronisers
    // ----------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // two stages for each encoder pin
    logic [2:0] enc_s1;
    logic [2:0] enc_s2;
    seos_enc_s enc;
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            enc_s1 <= 3'h0;
            enc_s2 <= 3'h0;
        end else begin
            enc_s1 <= {enc_a_in, enc_b_in, enc_mark_in};
            enc_s2 <= enc_s1;
        end
    end
    assign enc = enc_s2;

    // ----------------------------------------
    // position counter
    // ----------------------------------------
    seos_cnt_s cnt;
    logic arm;
    seos_enc_counter u_cnt (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .enc_in(enc),
        .arm_in(arm),
        .cnt_out(cnt)
    );

    // ----------------------------------------
    // sequencer state
    // ----------------------------------------
    typedef struct packed {
        seos_state_e fsm;
        seos_src_e src;
        logic [11:0] shift;
        logic [11:0] target;
        logic [11:0] range;
        logic rev;
        logic last_rev;
        logic oriented;
        logic turn_pending;
        logic [11:0] travelled;
        logic cmd_d;
        logic up_to_speed;
        logic pos_loop;
        logic done;
        logic parked;
        logic from_above;
        logic [SPD_W-1:0] spd;
    } seos_top_state_s;

    seos_top_state_s st;
    seos_top_state_s next_st;

    // remaining distance in the direction of travel
    function automatic logic [11:0] seos_remaining(input logic [11:0] tgt, input logic [11:0] pos, input logic rv);
        seos_remaining = rv ? (pos - tgt) : (tgt - pos); // [R14]
    endfunction

    function automatic logic seos_in_window(input logic [11:0] tgt, input logic [11:0] pos, input logic [11:0] rng);
        logic [11:0] d;
        d = pos - tgt;
        seos_in_window = (d <= rng) || ((SEOS_REV_COUNTS_M1 - d) < rng);
    endfunction

    logic [11:0] remain;
    logic step;

    always_comb begin
        next_st = st;
        next_st.cmd_d = orient_cmd_in;
        remain = seos_remaining(st.target, cnt.count, st.rev);
        step = st.rev ? cnt.rev_step : cnt.fwd_step;
        if (!orient_cmd_in) begin
            next_st.fsm = SEOS_IDLE; // [R7]
            next_st.src = SEOS_SRC_REF; // [R7]
            next_st.up_to_speed = 1'b0;
            next_st.pos_loop = 1'b0;
            next_st.oriented = 1'b0;
            next_st.done = 1'b0;
            next_st.last_rev = motor_reverse_in;
            // a spindle that moves after release is no longer parked at its stop
            if (cnt.fwd_step || cnt.rev_step) begin
                next_st.parked = 1'b0; // [R8]
            end
        end else begin
            unique case (st.fsm)
                SEOS_IDLE: begin
                    if (!st.cmd_d) begin
                        next_st.shift = stop_position_shift_in; // [R1]
                        next_st.range = in_position_range_in;
                        next_st.from_above = meas_speed_in > orient_speed_in; // [R2]
                        // all-open bits give the zero reference
                        next_st.target = stop_pos_bits_in + stop_position_shift_in; // [R10] [R11] [R15]
                        next_st.src = SEOS_SRC_ORIENT; // [R1]
                        next_st.fsm = SEOS_TO_ORIENT;
                        unique case (orient_select_param_in)
                            SEOS_DIR_FWD: next_st.rev = 1'b0; // [R13]
                            SEOS_DIR_REV: next_st.rev = 1'b1; // [R13]
                            default: next_st.rev = st.last_rev; // [R13]
                        endcase
                    end
                end
                SEOS_TO_ORIENT: begin
                    if (st.from_above ? (meas_speed_in <= orient_speed_in) : (meas_speed_in >= orient_speed_in)) begin
                        next_st.up_to_speed = 1'b1; // [R2]
                        next_st.fsm = SEOS_WAIT_MARK;
                    end
                end
                SEOS_WAIT_MARK: begin
                    if (cnt.mark_seen) begin
                        next_st.fsm = SEOS_ORIENT_RUN; // [R3]
                        next_st.travelled = 12'h000;
                        next_st.turn_pending = st.parked; // [R8]
                        next_st.parked = 1'b0;
                    end
                end
                SEOS_ORIENT_RUN: begin
                    if (step) begin
                        next_st.travelled = st.travelled + 12'h001;
                        if (st.travelled == SEOS_REV_COUNTS_M1) begin
                            next_st.turn_pending = 1'b0; // [R8]
                        end
                    end
                    if (!st.turn_pending && remain <= SEOS_CREEP_HI_CNT && remain >= SEOS_CREEP_LO_CNT) begin
                        next_st.src = SEOS_SRC_CREEP; // [R4]
                        next_st.fsm = SEOS_CREEP;
                    end
                end
                SEOS_CREEP: begin
                    if (remain <= SEOS_LOOP_HI_CNT && remain >= SEOS_LOOP_LO_CNT) begin
                        next_st.pos_loop = 1'b1; // [R5]
                        next_st.src = SEOS_SRC_HOLD; // [R5]
                        next_st.fsm = SEOS_POS_LOOP;
                    end
                end
                SEOS_POS_LOOP: begin
                    next_st.done = seos_in_window(st.target, cnt.count, st.range); // [R6]
                    // machine-ready inputs are not consulted, so the oriented state holds
                    if (next_st.done) begin
                        next_st.oriented = 1'b1; // [R9]
                        next_st.parked = 1'b1; // [R8]
                    end
                end
            endcase
        end
        unique case (next_st.src)
            SEOS_SRC_REF: next_st.spd = speed_ref_in; // [R7]
            SEOS_SRC_ORIENT: next_st.spd = orient_speed_in; // [R1] [R3]
            SEOS_SRC_CREEP: next_st.spd = creep_speed_in; // [R4]
            SEOS_SRC_HOLD: next_st.spd = '0; // [R5]
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign arm = (st.fsm == SEOS_WAIT_MARK) || (st.fsm == SEOS_ORIENT_RUN) ||
                 (st.fsm == SEOS_CREEP) || (st.fsm == SEOS_POS_LOOP);

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign speed_target_out = st.spd;
    assign dir_reverse_out = st.rev;
    assign up_to_speed_out = st.up_to_speed;
    assign pos_loop_en_out = st.pos_loop;
    assign pos_target_out = st.target;
    assign orient_done_contact = st.done;
    assign oriented_out = st.oriented;
endmodule
`default_nettype wire

/* seos_orient_seq_assertions.sv */
// checker: port assertions for the orientation sequencer
`timescale 1ns/1ps
`default_nettype none
module seos_orient_seq_chk
    import seos_pkg::*;
#(
    parameter int SPD_W = SEOS_SPD_W
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic orient_cmd_in,
    input wire logic [11:0] stop_pos_bits_in,
    input wire logic [11:0] stop_position_shift_in,
    input wire logic [1:0] orient_select_param_in,
    input wire logic [SPD_W-1:0] speed_ref_in,
    input wire logic [SPD_W-1:0] orient_speed_in,
    input wire logic [SPD_W-1:0] creep_speed_in,
    input wire logic [SPD_W-1:0] meas_speed_in,
    input wire logic motor_reverse_in,
    input wire logic [SPD_W-1:0] speed_target_out,
    input wire logic dir_reverse_out,
    input wire logic up_to_speed_out,
    input wire logic pos_loop_en_out,
    input wire logic [11:0] pos_target_out,
    input wire logic orient_done_contact,
    input wire logic oriented_out
);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    // direction from which the measured speed approaches the orientation speed
    logic cmd_q;
    logic above_q;
    always_ff @(posedge sys_clk_in) begin
        cmd_q <= orient_cmd_in;
        if (orient_cmd_in && !cmd_q) begin
            above_q <= meas_speed_in > orient_speed_in;
        end
    end
    orient_speed_a: assert property ($rose(orient_cmd_in) && !oriented_out |=> speed_target_out == orient_speed_in)
        else $error("orientation speed not taken");
    target_sum_a: assert property ($rose(orient_cmd_in) && !oriented_out
        |=> pos_target_out == 12'($past(stop_pos_bits_in) + $past(stop_position_shift_in))) else $error("bad target");
    up_cause_a: assert property ($rose(up_to_speed_out) |->
        $past(above_q ? meas_speed_in <= orient_speed_in : meas_speed_in >= orient_speed_in))
        else $error("up to speed without speed");
    up_hold_a: assert property ($rose(up_to_speed_out) |-> (speed_target_out == orient_speed_in)[*2])
        else $error("speed left orientation speed");
    creep_order_a: assert property ($rose(speed_target_out == creep_speed_in)
        |-> $past(speed_target_out == orient_speed_in)) else $error("creep not from orientation speed");
    loop_stop_a: assert property (pos_loop_en_out |-> speed_target_out == '0)
        else $error("speed not zero in position loop");
    done_loop_a: assert property (orient_done_contact |-> pos_loop_en_out)
        else $error("done outside position loop");
    oriented_set_a: assert property ($rose(oriented_out) |-> orient_done_contact)
        else $error("oriented without done");
    release_ref_a: assert property ($fell(orient_cmd_in) |=> speed_target_out == speed_ref_in
        && !pos_loop_en_out && !oriented_out && !orient_done_contact) else $error("release not clean");
    dir_pick_a: assert property ($rose(orient_cmd_in) && !oriented_out |=> dir_reverse_out ==
        ($past(orient_select_param_in) == SEOS_DIR_REV || ($past(orient_select_param_in) != SEOS_DIR_FWD
        && $past(motor_reverse_in)))) else $error("bad direction");
    ready_keep_a: assert property (oriented_out && orient_cmd_in ##1 orient_cmd_in |-> oriented_out)
        else $error("oriented state lost");
    cover property ($rose(pos_loop_en_out));
    cover property ($rose(oriented_out));
    cover property ($rose(speed_target_out == creep_speed_in));
endmodule
bind seos_orient_seq seos_orient_seq_chk #(.SPD_W(SPD_W)) chk_i (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .orient_cmd_in(orient_cmd_in), .stop_pos_bits_in(stop_pos_bits_in), .stop_position_shift_in(stop_position_shift_in),
    .orient_select_param_in(orient_select_param_in), .speed_ref_in(speed_ref_in), .orient_speed_in(orient_speed_in),
    .creep_speed_in(creep_speed_in), .meas_speed_in(meas_speed_in), .motor_reverse_in(motor_reverse_in),
    .speed_target_out(speed_target_out), .dir_reverse_out(dir_reverse_out), .up_to_speed_out(up_to_speed_out),
    .pos_loop_en_out(pos_loop_en_out), .pos_target_out(pos_target_out),
    .orient_done_contact(orient_done_contact), .oriented_out(oriented_out));
`default_nettype wire

/* seos_pkg.sv */
// package: constants and carriers for the spindle encoder orientation sequencer
package seos_pkg;
    localparam int SEOS_POS_W = 12;
    localparam int SEOS_SPD_W = 16;
    localparam logic [11:0] SEOS_REV_COUNTS_M1 = 12'hfff;
    localparam logic [11:0] SEOS_REF_STOP_POS = 12'h000;
    // creep window: 146..225 deg of 4096 counts per turn
    localparam int SEOS_CREEP_LO_DEG = 146;
    localparam int SEOS_CREEP_HI_DEG = 225;
    localparam int SEOS_LOOP_LO_DEG = 15;
    localparam int SEOS_LOOP_HI_DEG = 25;
    localparam int SEOS_DEG_PER_REV = 360;
    localparam int SEOS_COUNTS_PER_REV = 4096;
    localparam logic [11:0] SEOS_CREEP_HI_CNT = 12'((SEOS_CREEP_HI_DEG * SEOS_COUNTS_PER_REV) / SEOS_DEG_PER_REV);
    localparam logic [11:0] SEOS_CREEP_LO_CNT = 12'((SEOS_CREEP_LO_DEG * SEOS_COUNTS_PER_REV) / SEOS_DEG_PER_REV);
    localparam logic [11:0] SEOS_LOOP_HI_CNT = 12'((SEOS_LOOP_HI_DEG * SEOS_COUNTS_PER_REV) / SEOS_DEG_PER_REV);
    localparam logic [11:0] SEOS_LOOP_LO_CNT = 12'((SEOS_LOOP_LO_DEG * SEOS_COUNTS_PER_REV) / SEOS_DEG_PER_REV);
    localparam logic [1:0] SEOS_DIR_PREV = 2'h0;
    localparam logic [1:0] SEOS_DIR_FWD = 2'h1;
    localparam logic [1:0] SEOS_DIR_REV = 2'h2;

    typedef enum logic [2:0] {
        SEOS_IDLE,
        SEOS_TO_ORIENT,
        SEOS_WAIT_MARK,
        SEOS_ORIENT_RUN,
        SEOS_CREEP,
        SEOS_POS_LOOP
    } seos_state_e;

    typedef enum logic [1:0] {
        SEOS_SRC_REF,
        SEOS_SRC_ORIENT,
        SEOS_SRC_CREEP,
        SEOS_SRC_HOLD
    } seos_src_e;

    // encoder pins, already synchronised
    typedef struct packed {
        logic phase_a;
        logic phase_b;
        logic mark;
    } seos_enc_s;

    typedef struct packed {
        logic [11:0] count;
        logic counting;
        logic fwd_step;
        logic rev_step;
        logic mark_seen;
    } seos_cnt_s;
endpackage

/* testbench.sv */
// testbench: directed orientation runs against the motor model
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import seos_pkg::*;
    localparam logic [15:0] REF_SPD = 16'h1000;
    localparam logic [15:0] ORI_SPD = 16'h0400;
    localparam logic [15:0] CRP_SPD = 16'h0040;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd = 1'b0;
    logic rdy = 1'b1;
    logic [11:0] stop_bits = 12'h000;
    logic [11:0] shift = 12'h000;
    logic [1:0] sel = 2'h1;
    logic mrev = 1'b0;
    logic slow = 1'b0;
    logic [15:0] ref_spd = REF_SPD;
    int marks = 0;
    logic enc_a, enc_b, mark, dir_rev, up, loop_en, done, oriented, is_creep;
    logic [15:0] meas, spd;
    logic [11:0] tgt, angle;
    int err_count = 0;
    int num_checks = 0;
    always_comb is_creep = (spd == CRP_SPD);
    initial forever #10 clk = ~clk;
    always @(posedge mark) marks++;
    seos_orient_seq uut (.sys_clk_in(clk), .resetn_in(rst_n), .orient_cmd_in(cmd), .machine_ready_in_a(rdy),
        .machine_ready_in_b(rdy), .stop_pos_bits_in(stop_bits), .stop_position_shift_in(shift),
        .in_position_range_in(12'h004), .orient_select_param_in(sel), .speed_ref_in(ref_spd),
        .orient_speed_in(ORI_SPD), .creep_speed_in(CRP_SPD), .meas_speed_in(meas), .motor_reverse_in(mrev),
        .enc_a_in(enc_a), .enc_b_in(enc_b), .enc_mark_in(mark), .speed_target_out(spd), .dir_reverse_out(dir_rev),
        .up_to_speed_out(up), .pos_loop_en_out(loop_en), .pos_target_out(tgt), .orient_done_contact(done),
        .oriented_out(oriented));
    seos_enc_model motor (.clk_in(clk), .slow_in(slow), .speed_in(spd), .rev_in(dir_rev), .loop_in(loop_en),
        .target_in(tgt), .meas_out(meas), .enc_a_out(enc_a), .enc_b_out(enc_b), .mark_out(mark), .angle_out(angle));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic pick(input int which);
        case (which)
            0: return up;
            1: return is_creep;
            2: return loop_en;
            default: return oriented;
        endcase
    endfunction
    task automatic wait_sig(input string name, input int which);
        int n = 0;
        while (pick(which) !== 1'b1 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(name, 16'h0001, 16'(pick(which)));
    endtask
    function automatic logic [11:0] remain(input logic rev);
        return rev ? 12'(angle - tgt) : 12'(tgt - angle);
    endfunction
    task automatic raise_cmd(input logic [11:0] stop, input logic [11:0] sh, input logic [1:0] s, input logic mr);
        @(negedge clk);
        stop_bits = stop;
        shift = sh;
        sel = s;
        mrev = mr;
        @(negedge clk);
        cmd = 1'b1;
        @(posedge clk);
        #1;
        chk("speed_orient", ORI_SPD, spd);
    endtask
    task automatic release_cmd(input logic [15:0] r);
        @(negedge clk);
        cmd = 1'b0;
        ref_spd = r;
        @(posedge clk);
        #1;
        chk("speed_ref", r, spd);
        chk("cleared", 16'h0000, {12'h000, oriented, done, up, loop_en});
    endtask
    task automatic run_orient(input logic [11:0] stop, input logic [11:0] sh, input logic [1:0] s,
        input logic [11:0] exp_tgt, input logic exp_dir, input int exp_marks);
        marks = 0;
        raise_cmd(stop, sh, s, 1'b0);
        chk("pos_target", 16'(exp_tgt), 16'(tgt));
        chk("dir", 16'(exp_dir), 16'(dir_rev));
        wait_sig("up_to_speed", 0);
        chk("speed_at_up", ORI_SPD, spd);
        wait_sig("creep", 1);
        chk("marks", 16'(exp_marks), 16'(marks));
        chk("creep_dist", 16'h0001, 16'(remain(exp_dir) inside {[12'd1661:12'd2560]}));
        wait_sig("pos_loop", 2);
        chk("loop_dist", 16'h0001, 16'(remain(exp_dir) inside {[12'd170:12'd284]}));
        chk("loop_speed", 16'h0000, spd);
        wait_sig("oriented", 3);
        chk("done_in_window", 16'h0001, 16'(done && (remain(0) <= 12'h004 || remain(1) <= 12'h004)));
    endtask
    task automatic test_done();
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        logic [1:0] sels [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
        logic revs [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
        logic dirs [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        repeat (4) @(posedge clk);
        #1;
        chk("reset_outs", 16'h0000, {1'b0, spd[14:0] | {dir_rev, up, loop_en, done, oriented, tgt[9:0]}});
        @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        run_orient(12'h200, 12'h010, SEOS_DIR_FWD, 12'h210, 1'b0, 1);
        @(negedge clk);
        rdy = 1'b0;
        repeat (5) @(negedge clk);
        rdy = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("ready_toggle", 16'h0003, {14'h0000, oriented, done});
        release_cmd(16'h0000);
        run_orient(12'h200, 12'h010, SEOS_DIR_FWD, 12'h210, 1'b0, 2);
        release_cmd(REF_SPD);
        slow = 1'b1;
        run_orient(12'hff0, 12'h020, SEOS_DIR_REV, 12'h010, 1'b1, 1);
        release_cmd(REF_SPD);
        slow = 1'b0;
        for (int i = 0; i < 5; i++) begin
            raise_cmd(12'h000, 12'h000, sels[i], revs[i]);
            chk("dir_select", 16'(dirs[i]), 16'(dir_rev));
            chk("zero_stop", 16'(SEOS_REF_STOP_POS), 16'(tgt));
            release_cmd(REF_SPD);
        end
        test_done();
    end
    initial begin
        repeat (95000) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule
`default_nettype wire
